// >>> rtl/gcm_core.sv
// How it works
// - Each monitor byte received under the handshake lands in the receive byte register.
// - Receive enable at 1 allows data-received and end flags; at 0 masks both.
// - Receive handshake at 0: acknowledge bit stays 1, data-received on packet's first byte.
// - Receive handshake at 1: device drives acknowledge, data-received for every byte.
// - Transmit enable at 1 allows acknowledged and abort flags; at 0 masks both.
// - Transmit handshake at 0: valid bit stays 1; at 1 device drives it.
// - Transmit active flag reads 1 during a transmission, 0 once it ended.
// - Software checks idle, writes byte, sets active; valid bit goes low the next frame.
// - Test loop at 1: serial output feeds serial input, external input ignored.
// - Remote loop-back returns received B1, B2 and D onto transmitted channels.
// - With bus enable at 1, power-up 1 with power-down 0 drives the serial output low.
// - Bus enable at 1 enables the serial bus and disables the S/T layer 1.
// - Received indication 1111 decodes as deactivation confirmation.
// - Received indication 0111 decodes as power-up indication.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
module gcm_core #(
  parameter int T2_U = gcm_pkg::T2_UNIT
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic dcl,
  input wire logic fsc,
  input wire logic din,
  output logic dout,
  output logic st_l1_enable,
  output logic powered_down,
  output logic irq
);
  import gcm_pkg::*;
  logic [2:0] pins_s;
  logic dcl_prev_q;
  logic rise;
  logic fall;
  logic din_eff;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic wr_now;
  logic rd_now;
  logic [4:0] bit_q, bit_d;
  logic [4:0] idx;
  logic [31:0] rx_sh_q, rx_sh_d;
  logic [31:0] word;
  logic [31:0] tx_q, tx_d;
  logic dout_q, dout_d;
  logic done;
  logic [7:0] mon_rx_q, mon_rx_d;
  logic [7:0] mon_tx_q, mon_tx_d;
  logic [3:0] mstat_q, mstat_d;
  logic [3:0] mctl_q, mctl_d;
  logic [7:0] mode_q, mode_d;
  logic [10:0] dtmr_q, dtmr_d;
  logic [IQ_W-1:0] ist_q, ist_d;
  logic [IQ_W-1:0] imask_q, imask_d;
  logic [IQ_W-1:0] ev;
  logic [3:0] ind_q, ind_d;
  logic [3:0] cmd_q, cmd_d;
  logic mx_prev_q, mx_prev_d;
  logic rx_pkt_q, rx_pkt_d;
  logic mr_ack_q, mr_ack_d;
  gcm_tx_t txs_q, txs_d;
  logic irq_q;
  logic stl1_q;
  logic pdn_q;
  logic t1_hit, t2_hit;
  logic mac, ge, local_test_loop, remote_loopback;

  // Pins from the link side are foreign to mclk
  gcm_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({dcl, fsc, din}),
    .stable_q(pins_s)
  );

  gcm_dtimer #(.T1_U(T1_UNIT), .T2_U(T2_U)) u_tmr (
    .mclk(mclk),
    .reset_n(reset_n),
    .tick(rise),
    .run(local_test_loop && ge),
    .val(dtmr_q[7:0]),
    .cnt(dtmr_q[10:8]),
    .t1_hit_q(t1_hit),
    .t2_hit_q(t2_hit)
  );

  assign mac = mode_q[MD_MAC];
  assign ge = mode_q[MD_GE];
  assign local_test_loop = mode_q[MD_TLP];
  assign remote_loopback = mode_q[MD_REMOTE_LOOPBACK];
  assign rise = pins_s[2] && !dcl_prev_q;
  assign fall = !pins_s[2] && dcl_prev_q;
  // Looped data never sees the pin
  assign din_eff = local_test_loop ? dout_q : pins_s[0];
  assign idx = pins_s[1] ? 5'd0 : bit_q;
  assign word = {rx_sh_q[30:0], din_eff};
  assign done = rise && ge && (idx == 5'(FR_LAST));
  // Request accepted at the edge where waitrequest is seen low
  assign wr_now = write && !wait_q;
  assign rd_now = read && !wait_q;

  // Bus slave: one wait cycle, data registered in it
  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if ((read || write) && wait_q) begin
      wait_d = 1'b0;
      rdata_d = '0;
      case (address)
        ADDR_MON_RX: rdata_d[7:0] = mon_rx_q;
        ADDR_MON_TX: rdata_d[7:0] = mon_tx_q;
        ADDR_MON_STAT: rdata_d[3:0] = mstat_q;
        ADDR_MON_CTRL: rdata_d[3:0] = mctl_q;
        ADDR_MODE: rdata_d[7:0] = mode_q;
        ADDR_DTIMER: rdata_d[10:0] = dtmr_q;
        ADDR_IRQ_STAT: rdata_d[IQ_W-1:0] = ist_q;
        ADDR_IRQ_MASK: rdata_d[IQ_W-1:0] = imask_q;
        ADDR_IND: rdata_d[5:0] = {ind_q == IND_PU, ind_q == IND_DC, ind_q};
        ADDR_CMD: rdata_d[3:0] = cmd_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Frame timing, monitor handshake and registers
  always_comb begin
    bit_d = bit_q;
    rx_sh_d = rx_sh_q;
    tx_d = tx_q;
    dout_d = dout_q;
    mon_rx_d = mon_rx_q;
    mon_tx_d = mon_tx_q;
    mctl_d = mctl_q;
    mode_d = mode_q;
    dtmr_d = dtmr_q;
    imask_d = imask_q;
    ind_d = ind_q;
    cmd_d = cmd_q;
    mx_prev_d = mx_prev_q;
    rx_pkt_d = rx_pkt_q;
    mr_ack_d = mr_ack_q;
    txs_d = txs_q;
    ev = '0;
    // Shift in on the rising data clock edge
    if (rise && ge) begin
      rx_sh_d = word;
      bit_d = idx + 5'd1;
    end
    // Frame end: act on the whole received word
    if (done) begin
      if (!word[FR_MX] && mx_prev_q) begin
        mon_rx_d = word[FR_MON+:8];
        rx_pkt_d = 1'b1;
        ev[MS_MDR] = mctl_q[MC_RECEIVE_IRQ_ENABLE] && (mctl_q[MC_MRC] || !rx_pkt_q);
        mr_ack_d = mctl_q[MC_MRC];
      end else begin
        mr_ack_d = 1'b0;
      end
      if (word[FR_MX] && mx_prev_q && rx_pkt_q) begin
        rx_pkt_d = 1'b0;
        ev[MS_MER] = mctl_q[MC_RECEIVE_IRQ_ENABLE];
      end
      mx_prev_d = word[FR_MX];
      // Transmit side watches the far end's acknowledge
      case (txs_q)
        GCM_TX_IDLE: begin
          if (mac) begin
            txs_d = GCM_TX_FIRST;
          end
        end
        GCM_TX_FIRST: begin
          if (!word[FR_MR]) begin
            ev[MS_MAB] = 1'b1;
            txs_d = GCM_TX_IDLE;
          end else begin
            txs_d = GCM_TX_WAIT;
          end
        end
        GCM_TX_WAIT: begin
          if (!word[FR_MR]) begin
            ev[MS_MDA] = 1'b1;
            txs_d = GCM_TX_IDLE;
          end
        end
        default: txs_d = GCM_TX_IDLE;
      endcase
      // End of transmission frees the active flag
      if (ev[MS_MAB] || ev[MS_MDA]) begin
        mode_d[MD_MAC] = 1'b0;
      end
      if (word[FR_CI+:4] != ind_q) begin
        ind_d = word[FR_CI+:4];
        ev[IQ_IND] = 1'b1;
      end
      // Next frame: loop-back or idle channels, then monitor bits
      tx_d[FR_B1+:8] = remote_loopback ? word[FR_B1+:8] : IDLE_BYTE;
      tx_d[FR_B2+:8] = remote_loopback ? word[FR_B2+:8] : IDLE_BYTE;
      tx_d[FR_D+:2] = remote_loopback ? word[FR_D+:2] : 2'b11;
      tx_d[FR_MON+:8] = mon_tx_q;
      tx_d[FR_CI+:4] = cmd_q;
      tx_d[FR_MR] = !mr_ack_d;
      tx_d[FR_MX] = !(mctl_q[MC_MXC] && mode_d[MD_MAC]);
    end
    ev[MS_MDA] = ev[MS_MDA] && mctl_q[MC_TRANSMIT_IRQ_ENABLE];
    ev[MS_MAB] = ev[MS_MAB] && mctl_q[MC_TRANSMIT_IRQ_ENABLE];
    ev[IQ_T1] = t1_hit;
    ev[IQ_T2] = t2_hit;
    // Output bit changes on the falling edge, held for the far end
    if (!ge) begin
      dout_d = 1'b1;
    end else if (mode_q[MD_SPU] && !mode_q[MD_PD]) begin
      dout_d = 1'b0;
    end else if (fall) begin
      dout_d = tx_q[5'(FR_LAST) - bit_q];
    end
    if (wr_now) begin
      case (address)
        ADDR_MON_TX: mon_tx_d = writedata[7:0];
        ADDR_MON_CTRL: mctl_d = writedata[3:0];
        ADDR_MODE: begin
          mode_d[6:0] = writedata[6:0];
          // Software may only start; hardware ends it
          if (writedata[MD_MAC]) begin
            mode_d[MD_MAC] = 1'b1;
          end
        end
        ADDR_DTIMER: dtmr_d = writedata[10:0];
        ADDR_IRQ_MASK: imask_d = writedata[IQ_W-1:0];
        ADDR_CMD: cmd_d = writedata[3:0];
        default: ;
      endcase
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_comb begin
    mstat_d = mstat_q;
    ist_d = ist_q;
    if (rd_now && address == ADDR_MON_STAT) begin
      mstat_d = '0;
    end
    if (wr_now && address == ADDR_IRQ_STAT) begin
      ist_d = ist_q & ~writedata[IQ_W-1:0];
    end
    mstat_d = mstat_d | ev[3:0];
    ist_d = ist_d | ev;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dcl_prev_q <= 1'b1;
      bit_q <= '0;
      rx_sh_q <= '1;
      tx_q <= '1;
      dout_q <= 1'b1;
      mon_rx_q <= RST_MON_RX;
      mon_tx_q <= RST_MON_TX;
      mstat_q <= '0;
      mctl_q <= '0;
      mode_q <= '0;
      dtmr_q <= '0;
      ist_q <= '0;
      imask_q <= '0;
      ind_q <= RST_CODE;
      cmd_q <= RST_CODE;
      mx_prev_q <= 1'b1;
      rx_pkt_q <= 1'b0;
      mr_ack_q <= 1'b0;
      txs_q <= GCM_TX_IDLE;
      irq_q <= 1'b0;
      stl1_q <= 1'b1;
      pdn_q <= 1'b0;
    end else begin
      dcl_prev_q <= pins_s[2];
      bit_q <= bit_d;
      rx_sh_q <= rx_sh_d;
      tx_q <= tx_d;
      dout_q <= dout_d;
      mon_rx_q <= mon_rx_d;
      mon_tx_q <= mon_tx_d;
      mstat_q <= mstat_d;
      mctl_q <= mctl_d;
      mode_q <= mode_d;
      dtmr_q <= dtmr_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      ind_q <= ind_d;
      cmd_q <= cmd_d;
      mx_prev_q <= mx_prev_d;
      rx_pkt_q <= rx_pkt_d;
      mr_ack_q <= mr_ack_d;
      txs_q <= txs_d;
      irq_q <= |(ist_d & imask_d);
      stl1_q <= !mode_d[MD_GE];
      pdn_q <= mode_d[MD_PD] && !mode_d[MD_SPU];
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign dout = dout_q;
  assign st_l1_enable = stl1_q;
  assign powered_down = pdn_q;
  assign irq = irq_q;
endmodule : gcm_core

// >>> rtl/gcm_pkg.sv
package gcm_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_MON_RX = 8'h6c;
  localparam logic [7:0] ADDR_MON_TX = 8'h70;
  localparam logic [7:0] ADDR_MON_STAT = 8'h74;
  localparam logic [7:0] ADDR_MON_CTRL = 8'h78;
  localparam logic [7:0] ADDR_MODE = 8'h7c;
  localparam logic [7:0] ADDR_DTIMER = 8'hc0;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hc4;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hc8;
  localparam logic [7:0] ADDR_IND = 8'hcc;
  localparam logic [7:0] ADDR_CMD = 8'hd0;
  // Values after reset
  localparam logic [7:0] RST_MON_RX = 8'hff;
  localparam logic [7:0] RST_MON_TX = 8'hff;
  localparam logic [3:0] RST_CODE = 4'hf;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  // Monitor status and control bit positions
  localparam int MS_MDR = 3;
  localparam int MS_MER = 2;
  localparam int MS_MDA = 1;
  localparam int MS_MAB = 0;
  localparam int MC_RECEIVE_IRQ_ENABLE = 3;
  localparam int MC_MRC = 2;
  localparam int MC_TRANSMIT_IRQ_ENABLE = 1;
  localparam int MC_MXC = 0;
  // Mode control bit positions
  localparam int MD_MAC = 7;
  localparam int MD_TLP = 4;
  localparam int MD_REMOTE_LOOPBACK = 3;
  localparam int MD_SPU = 2;
  localparam int MD_PD = 1;
  localparam int MD_GE = 0;
  // Interrupt status bit positions
  localparam int IQ_W = 7;
  localparam int IQ_IND = 4;
  localparam int IQ_T1 = 5;
  localparam int IQ_T2 = 6;
  // Frame word, first bit on the wire is bit 31
  localparam int FR_LAST = 31;
  localparam int FR_B1 = 24;
  localparam int FR_B2 = 16;
  localparam int FR_MON = 8;
  localparam int FR_D = 6;
  localparam int FR_CI = 2;
  localparam int FR_MR = 1;
  localparam int FR_MX = 0;
  // Indication codes
  localparam logic [3:0] IND_DC = 4'b1111;
  localparam logic [3:0] IND_PU = 4'b0111;
  // Test loop timer multipliers, in data clock periods
  localparam int T1_UNIT = 512;
  localparam int T2_UNIT = 16348;
  localparam int TMR_W = 20;
  // Monitor transmit states, Gray along the path
  typedef enum logic [1:0] {
    GCM_TX_IDLE = 2'b00,
    GCM_TX_FIRST = 2'b01,
    GCM_TX_WAIT = 2'b11
  } gcm_tx_t;
endpackage : gcm_pkg

// >>> rtl/gcm_sync.sv
`timescale 1ns/100ps
module gcm_sync #(
  parameter int W = 3
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] stable_q
);
  import gcm_pkg::*;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] stable_d;

  // Accept a change once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
      end
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q[i] <= 1'b1;
          s2_q[i] <= 1'b1;
          s3_q[i] <= 1'b1;
          stable_q[i] <= 1'b1;
        end else begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          stable_q[i] <= stable_d[i];
        end
      end
    end
  endgenerate
endmodule : gcm_sync

// >>> rtl/gcm_dtimer.sv
`timescale 1ns/100ps
module gcm_dtimer #(
  parameter int T1_U = gcm_pkg::T1_UNIT,
  parameter int T2_U = gcm_pkg::T2_UNIT
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic run,
  input wire logic [7:0] val,
  input wire logic [2:0] cnt,
  output logic t1_hit_q,
  output logic t2_hit_q
);
  import gcm_pkg::*;
  logic [TMR_W-1:0] ctr_q;
  logic [TMR_W-1:0] ctr_d;
  logic [TMR_W-1:0] t1_len;
  logic [TMR_W-1:0] t2_len;
  logic t1_hit_d;
  logic t2_hit_d;

  // Shortened constants while looped: counts in data clock periods
  always_comb begin
    t1_len = TMR_W'(T1_U * (int'(val) + 1));
    t2_len = TMR_W'(T2_U * int'(cnt)) + t1_len;
    ctr_d = ctr_q;
    t1_hit_d = 1'b0;
    t2_hit_d = 1'b0;
    if (!run) begin
      ctr_d = '0;
    end else if (tick && ctr_q != t2_len) begin
      ctr_d = ctr_q + 1'b1;
      t1_hit_d = (ctr_d == t1_len);
      t2_hit_d = (ctr_d == t2_len) && (cnt != 3'd0);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctr_q <= '0;
      t1_hit_q <= 1'b0;
      t2_hit_q <= 1'b0;
    end else begin
      ctr_q <= ctr_d;
      t1_hit_q <= t1_hit_d;
      t2_hit_q <= t2_hit_d;
    end
  end
endmodule : gcm_dtimer

// >>> testbench/gcm_core_assertions.sv
`timescale 1ns/100ps
module gcm_core_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic dout,
  input wire logic st_l1_enable,
  input wire logic powered_down,
  input wire logic irq
);
  import gcm_pkg::*;
  logic [7:0] mode_d, mode_q, mctl_d, mctl_q, cnt_d, cnt_q;
  logic take_w;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Shadow of what software wrote; cnt_q gives outputs time to settle
  always_comb begin
    take_w = write && !waitrequest;
    mode_d = (take_w && address == ADDR_MODE) ? writedata[7:0] : mode_q;
    mctl_d = (take_w && address == ADDR_MON_CTRL) ? writedata[7:0] : mctl_q;
    cnt_d = (take_w && address == ADDR_MODE) ? 8'h00 : cnt_q + {7'h0, cnt_q != 8'hff};
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= 8'h00;
      mctl_q <= 8'h00;
      cnt_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      mctl_q <= mctl_d;
      cnt_q <= cnt_d;
    end
  end
  wait_one_a: assert property ($rose(read || write) |=> !waitrequest)
    else $error("access not answered after one cycle");
  wait_short_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  unmapped_zero_a: assert property (read && !waitrequest
    && (address < ADDR_MON_RX || address > ADDR_CMD) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  bus_enable_a: assert property (cnt_q > 8'h04 |-> st_l1_enable == !mode_q[MD_GE])
    else $error("layer 1 enable disagrees with bus enable");
  power_low_a: assert property (cnt_q > 8'h28 && mode_q[2:0] == 3'b101 |-> !dout)
    else $error("dout not held low in power up request");
  idle_high_a: assert property (cnt_q > 8'h28 && mode_q[2:0] == 3'b000 |-> dout)
    else $error("dout not high with bus disabled");
  power_state_a: assert property (cnt_q > 8'h04 |->
    powered_down == (mode_q[MD_PD] && !mode_q[MD_SPU]))
    else $error("powered_down wrong");
  mode_back_a: assert property (read && !waitrequest && address == ADDR_MODE |->
    readdata[4:0] == mode_q[4:0])
    else $error("mode readback wrong");
  ctrl_back_a: assert property (read && !waitrequest && address == ADDR_MON_CTRL |->
    readdata[3:0] == mctl_q[3:0])
    else $error("monitor control readback wrong");
  irq_off_a: assert property (take_w && address == ADDR_IRQ_MASK && writedata[7:0] == 8'h00
    |-> ##[1:2] !irq)
    else $error("irq high with all masked");
  rx_seen_c: cover property (read && !waitrequest && address == ADDR_MON_STAT && readdata[MS_MDR]);
  irq_seen_c: cover property ($rose(irq));
  pd_seen_c: cover property ($rose(powered_down));
endmodule : gcm_core_chk

bind gcm_core gcm_core_chk i_chk (
  .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .dout(dout),
  .st_l1_enable(st_l1_enable), .powered_down(powered_down), .irq(irq)
);

// >>> testbench/gcm_utx_model.sv
`timescale 1ns/100ps
module gcm_utx (
  input wire logic dout,
  input wire logic [31:0] tx_word,
  output logic dcl,
  output logic fsc,
  output logic din,
  output logic [31:0] rx_word,
  output int frames
);
  logic [31:0] sh_q;
  logic [31:0] cap_q;
  int bit_q;
  // Idle frame content until the bench asks for more
  initial begin
    dcl = 1'b1;
    fsc = 1'b0;
    din = 1'b1;
    rx_word = 32'hffffffff;
    cap_q = 32'hffffffff;
    sh_q = 32'hffffffff;
    frames = 0;
    bit_q = 0;
  end
  // Transceiver supplies bus clocking at all times
  always #80 dcl = ~dcl;
  // Sample dout at the fall, well clear of its late change; drive din 40 ns after
  always @(negedge dcl) begin
    cap_q = {cap_q[30:0], dout};
    if (bit_q == 0) begin
      rx_word = cap_q;
      frames++;
      sh_q = tx_word;
    end
    #40;
    din = sh_q[31 - bit_q];
    fsc = (bit_q == 0);
    bit_q = (bit_q + 1) % 32;
  end
endmodule : gcm_utx

// >>> testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import gcm_pkg::*;
  logic mclk, reset_n, read, write, waitrequest, dcl, fsc, din, dout;
  logic st_l1_enable, powered_down, irq;
  logic [7:0] address;
  logic [31:0] writedata, readdata, tx_word, rx_word, q;
  int frames, bad_count, compares;
  gcm_core #(.T2_U(4)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .dcl(dcl),
    .fsc(fsc), .din(din), .dout(dout), .st_l1_enable(st_l1_enable),
    .powered_down(powered_down), .irq(irq)
  );
  gcm_utx i_utx (
    .dout(dout), .tx_word(tx_word), .dcl(dcl), .fsc(fsc), .din(din),
    .rx_word(rx_word), .frames(frames)
  );
  // 50 MHz system clock
  always #10 mclk = ~mclk;
  task automatic final_report;
    $display("Counts: %0d compares, %0d bad", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 40) begin
      bad_count++;
      final_report();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(q[7:0] & m, e);
  endtask : rd
  // Wait whole link frames, with a margin for the pin synchronisers
  task automatic wf(input int n);
    int f0;
    int k;
    f0 = frames;
    k = 0;
    while (frames < f0 + n && k < 300 * n) begin
      @(posedge mclk);
      k++;
    end
    if (frames < f0 + n) begin
      bad_count++;
      final_report();
    end
    repeat (10) @(posedge mclk);
  endtask : wf
  task automatic settle(input logic [7:0] e, input logic got_sel);
    repeat (3) @(posedge mclk);
    chk({7'h0, got_sel ? powered_down : irq}, e);
  endtask : settle
  task automatic send(input logic [7:0] b);
    tx_word <= {16'hffff, b, 8'hfe};
    wf(1);
    tx_word <= 32'hffffffff;
    wf(1);
  endtask : send
  task automatic t_reset;
    rd(ADDR_MON_RX, 8'hff, RST_MON_RX);
    rd(ADDR_MON_TX, 8'hff, RST_MON_TX);
    rd(ADDR_MON_STAT, 8'hff, 8'h00);
    rd(ADDR_MON_CTRL, 8'hff, 8'h00);
    rd(ADDR_MODE, 8'hff, 8'h00);
    rd(8'he0, 8'hff, 8'h00);
    rd(ADDR_CMD, 8'h0f, {4'h0, RST_CODE});
    chk({7'h0, st_l1_enable}, 8'h01);
    // Long enough with the bus off for the idle-level assertion to look
    repeat (50) @(posedge mclk);
    chk({7'h0, dout}, 8'h01);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_MON_RX, 8'h00);
    rd(ADDR_MON_RX, 8'hff, 8'hff);
    chk({7'h0, st_l1_enable}, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_rx;
    wr(ADDR_MON_CTRL, 8'h0c);
    send(8'h5a);
    // Second byte of the same packet, no end of reception between
    tx_word <= {16'hffff, 8'h66, 8'hfe};
    wf(1);
    chk({7'h0, rx_word[FR_MR]}, 8'h00);
    rd(ADDR_MON_RX, 8'hff, 8'h5a);
    rd(ADDR_MON_STAT, 8'hff, 8'h08);
    tx_word <= 32'hffffffff;
    wf(3);
    rd(ADDR_MON_STAT, 8'hff, 8'h0c);
    rd(ADDR_MON_RX, 8'hff, 8'h66);
    rd(ADDR_MON_STAT, 8'hff, 8'h00);
    wr(ADDR_MON_CTRL, 8'h08);
    send(8'h33);
    rd(ADDR_MON_STAT, 8'hff, 8'h08);
    send(8'h44);
    chk({7'h0, rx_word[FR_MR]}, 8'h01);
    rd(ADDR_MON_STAT, 8'hff, 8'h00);
    wr(ADDR_MON_CTRL, 8'h00);
    send(8'h55);
    wf(2);
    rd(ADDR_MON_STAT, 8'hff, 8'h00);
    rd(ADDR_MON_RX, 8'hff, 8'h55);
    $display("receive test done");
  endtask : t_rx
  task automatic t_ind;
    wr(ADDR_IRQ_MASK, 8'h10);
    rd(ADDR_IRQ_MASK, 8'hff, 8'h10);
    tx_word <= 32'hffffffdf;
    wf(3);
    rd(ADDR_IND, 8'h3f, 8'h27);
    settle(8'h01, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h00);
    settle(8'h00, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h10);
    settle(8'h01, 1'b0);
    wr(ADDR_IRQ_STAT, 8'h10);
    settle(8'h00, 1'b0);
    tx_word <= 32'hffffffff;
    wf(3);
    rd(ADDR_IND, 8'h3f, 8'h1f);
    wr(ADDR_IRQ_STAT, 8'h7f);
    $display("indication test done");
  endtask : t_ind
  task automatic t_tx;
    logic [7:0] ctl [3] = '{8'h03, 8'h03, 8'h01};
    logic [7:0] ex [3] = '{8'h02, 8'h01, 8'h00};
    logic early [3] = '{1'b0, 1'b1, 1'b0};
    chk({7'h0, rx_word[FR_MX]}, 8'h01);
    // Acknowledge, abort in first frame, and masked flags
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_MON_CTRL, ctl[i]);
      wr(ADDR_MON_TX, 8'ha5);
      tx_word <= early[i] ? 32'hfffffffd : 32'hffffffff;
      wf(1);
      rd(ADDR_MODE, 8'h80, 8'h00);
      wr(ADDR_MODE, 8'h81);
      rd(ADDR_MODE, 8'h80, 8'h80);
      wf(2);
      chk(rx_word[15:8], 8'ha5);
      chk({7'h0, rx_word[FR_MX]}, 8'h00);
      tx_word <= 32'hfffffffd;
      wf(2);
      tx_word <= 32'hffffffff;
      wf(1);
      rd(ADDR_MODE, 8'h80, 8'h00);
      rd(ADDR_MON_STAT, 8'h03, ex[i]);
    end
    $display("transmit test done");
  endtask : t_tx
  task automatic t_loop;
    wr(ADDR_MODE, 8'h09);
    tx_word <= 32'h1234ff7f;
    wf(3);
    chk(rx_word[31:24], 8'h12);
    chk(rx_word[23:16], 8'h34);
    chk({6'h0, rx_word[7:6]}, 8'h01);
    wr(ADDR_MODE, 8'h01);
    tx_word <= 32'hffffffff;
    $display("remote loop test done");
  endtask : t_loop
  task automatic t_pwr;
    wr(ADDR_MODE, 8'h05);
    wf(2);
    chk({7'h0, |rx_word}, 8'h00);
    wr(ADDR_MODE, 8'h03);
    settle(8'h01, 1'b1);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CMD, 8'h08);
    wf(2);
    chk({4'h0, rx_word[5:2]}, 8'h08);
    $display("power test done");
  endtask : t_pwr
  // Own transmission comes back inside; the outside byte must not land
  task automatic t_tlp;
    bus(1'b1, ADDR_DTIMER, 32'h00000100);
    rd(ADDR_DTIMER, 8'hff, 8'h00);
    chk({5'h0, q[10:8]}, 8'h01);
    wr(ADDR_MON_CTRL, 8'h01);
    wr(ADDR_MON_TX, 8'hc3);
    tx_word <= 32'hffff77fe;
    wr(ADDR_MODE, 8'h91);
    repeat (3900) @(posedge mclk);
    rd(ADDR_IRQ_STAT, 8'h60, 8'h00);
    // First constant at 512 data clocks, second 4 data clocks later
    repeat (200) @(posedge mclk);
    rd(ADDR_IRQ_STAT, 8'h60, 8'h20);
    repeat (300) @(posedge mclk);
    rd(ADDR_IRQ_STAT, 8'h60, 8'h60);
    rd(ADDR_MON_RX, 8'hff, 8'hc3);
    $display("test loop test done");
  endtask : t_tlp
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    tx_word = 32'hffffffff;
    bad_count = 0;
    compares = 0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_rx();
    t_ind();
    t_tx();
    t_loop();
    t_pwr();
    t_tlp();
    final_report();
  end
endmodule : testbench
